// ==== verilog/pmief_flags.sv ====
// Purpose : identification register, first event-flag register and interrupt pin
// Assumes : serial link clock arrives on scl_clk; event inputs are on sys_clk
// Notes   : link side runs on scl_clk, flags and mask on sys_clk

`timescale 1ns/1ns
`default_nettype none

module pmief_flags #(
    parameter logic [6:0]                   DEV_ADDR     = 7'h2a, // arbitrary value
    parameter logic [pmief_pkg::PART_W-1:0] PART_CODE    = 5'h03, // arbitrary value
    parameter logic [pmief_pkg::STEP_W-1:0] SILICON_STEP = 3'h1   // arbitrary value
) (
    // system clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rstn,
    // serial link
    input  wire logic                     scl_clk,
    input  wire logic                     sda_i,
    output logic                          sda_o,
    output logic                          sda_oe_n,
    // monitored pins
    input  wire logic                     adapter_detect_pin,
    input  wire logic                     button_pin,
    // internal event sources
    input  wire pmief_pkg::pmief_events_t events,
    // interrupt
    output logic                          irq_out_n
);

    generate
        if (DEV_ADDR == 7'h00) begin : g_bad_addr
            $error("device address zero is the general call address");
        end
    endgenerate

    // ----------------------------------------------------------------
    // start detection
    // ----------------------------------------------------------------
    // sda falling while scl is high marks a start; this flop toggles so
    // that the link logic can spot it at the next scl rise, which the
    // bus guarantees comes well after the start hold time
    logic start_tog;
    logic next_start_tog;

    always_comb begin
        next_start_tog = scl_clk ? ~start_tog : start_tog;
    end

    always_ff @(negedge sda_i or negedge rstn) begin
        if (!rstn) begin
            start_tog <= 1'b0;
        end else begin
            start_tog <= next_start_tog;
        end
    end

    // ----------------------------------------------------------------
    // link receive side, sampled on scl rise
    // ----------------------------------------------------------------
    pmief_pkg::pmief_state_t state;
    pmief_pkg::pmief_state_t next_state;
    pmief_pkg::pmief_wr_t    wr;
    pmief_pkg::pmief_wr_t    next_wr;
    logic [3:0]              bitcnt;
    logic [3:0]              next_bitcnt;
    logic [7:0]              shift;
    logic [7:0]              next_shift;
    logic [7:0]              ptr;
    logic [7:0]              next_ptr;
    logic                    have_ptr;
    logic                    next_have_ptr;
    logic                    rw;
    logic                    next_rw;
    logic                    rd_tog;
    logic                    next_rd_tog;
    logic                    wr_tog;
    logic                    next_wr_tog;
    logic                    start_seen;
    logic                    next_start_seen;
    logic [7:0]              byte_in;

    always_comb begin
        byte_in         = {shift[6:0], sda_i};
        next_state      = state;
        next_wr         = wr;
        next_bitcnt     = bitcnt;
        next_shift      = shift;
        next_ptr        = ptr;
        next_have_ptr   = have_ptr;
        next_rw         = rw;
        next_rd_tog     = rd_tog;
        next_wr_tog     = wr_tog;
        next_start_seen = start_seen;
        if (start_tog != start_seen) begin
            // first address bit is sampled on the same rise
            next_start_seen = start_tog;
            next_state      = pmief_pkg::ST_ADDR;
            next_bitcnt     = pmief_pkg::BIT_FIRST;
            next_shift      = {7'h00, sda_i};
            next_have_ptr   = 1'b0;
        end else begin
            case (state)
                pmief_pkg::ST_ADDR: begin
                    next_shift  = byte_in;
                    next_bitcnt = bitcnt + 4'h1;
                    if (bitcnt == pmief_pkg::BIT_LAST) begin
                        if (byte_in[7:1] == DEV_ADDR) begin
                            next_state = pmief_pkg::ST_AACK;
                            next_rw    = byte_in[0];
                            // read: ask the system side for the byte at ptr
                            if (byte_in[0]) begin
                                next_rd_tog = ~rd_tog;
                            end
                        end else begin
                            next_state = pmief_pkg::ST_IDLE;
                        end
                    end
                end
                pmief_pkg::ST_AACK: begin
                    next_bitcnt = pmief_pkg::BIT_ZERO;
                    next_state  = rw ? pmief_pkg::ST_TX : pmief_pkg::ST_RX;
                end
                pmief_pkg::ST_RX: begin
                    next_shift  = byte_in;
                    next_bitcnt = bitcnt + 4'h1;
                    if (bitcnt == pmief_pkg::BIT_LAST) begin
                        next_state = pmief_pkg::ST_WACK;
                        if (!have_ptr) begin
                            next_ptr      = byte_in;
                            next_have_ptr = 1'b1;
                        end else begin
                            next_wr.addr = ptr;
                            next_wr.data = byte_in;
                            next_wr_tog  = ~wr_tog;
                            next_ptr     = ptr + 8'h01;
                        end
                    end
                end
                pmief_pkg::ST_WACK: begin
                    next_bitcnt = pmief_pkg::BIT_ZERO;
                    next_state  = pmief_pkg::ST_RX;
                end
                pmief_pkg::ST_TX: begin
                    next_bitcnt = bitcnt + 4'h1;
                    if (bitcnt == pmief_pkg::BIT_LAST) begin
                        next_state = pmief_pkg::ST_MACK;
                    end
                end
                pmief_pkg::ST_MACK: begin
                    next_bitcnt = pmief_pkg::BIT_ZERO;
                    if (!sda_i) begin
                        next_ptr    = ptr + 8'h01;
                        next_rd_tog = ~rd_tog;
                        next_state  = pmief_pkg::ST_TX;
                    end else begin
                        next_state = pmief_pkg::ST_IDLE;
                    end
                end
                default: begin
                    next_state = pmief_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge scl_clk or negedge rstn) begin
        if (!rstn) begin
            state      <= pmief_pkg::ST_IDLE;
            wr         <= '0;
            bitcnt     <= pmief_pkg::BIT_ZERO;
            shift      <= 8'h00;
            ptr        <= 8'h00;
            have_ptr   <= 1'b0;
            rw         <= 1'b0;
            rd_tog     <= 1'b0;
            wr_tog     <= 1'b0;
            start_seen <= 1'b0;
        end else begin
            state      <= next_state;
            wr         <= next_wr;
            bitcnt     <= next_bitcnt;
            shift      <= next_shift;
            ptr        <= next_ptr;
            have_ptr   <= next_have_ptr;
            rw         <= next_rw;
            rd_tog     <= next_rd_tog;
            wr_tog     <= next_wr_tog;
            start_seen <= next_start_seen;
        end
    end

    // ----------------------------------------------------------------
    // link drive side, updated on scl fall
    // ----------------------------------------------------------------
    // rd_data is a system-domain word held still between requests; the
    // low phase of scl far exceeds the few system cycles needed to load it
    logic [7:0] rd_data;
    logic       drive_low;
    logic       next_drive_low;

    always_comb begin
        case (state)
            pmief_pkg::ST_AACK: begin
                next_drive_low = 1'b1;
            end
            pmief_pkg::ST_WACK: begin
                next_drive_low = 1'b1;
            end
            pmief_pkg::ST_TX: begin
                next_drive_low = ~rd_data[~bitcnt[2:0]];
            end
            default: begin
                next_drive_low = 1'b0;
            end
        endcase
    end

    always_ff @(negedge scl_clk or negedge rstn) begin
        if (!rstn) begin
            drive_low <= 1'b0;
        end else begin
            drive_low <= next_drive_low;
        end
    end

    assign sda_o    = 1'b0;
    assign sda_oe_n = ~drive_low;

    // ----------------------------------------------------------------
    // crossings into the system clock
    // ----------------------------------------------------------------
    logic [3:0] filt;
    logic [3:0] filt_q;
    logic [3:0] next_filt_q;

    pmief_sync3 #(
        .W (4)
    ) u_sync (
        .clk  (sys_clk),
        .rstn (rstn),
        .d    ({wr_tog, rd_tog, button_pin, adapter_detect_pin}),
        .q    (filt)
    );

    logic rd_evt;
    logic wr_evt;
    logic adapter_chg;
    logic button_chg;

    always_comb begin
        next_filt_q = filt;
        rd_evt      = filt[2] ^ filt_q[2];
        wr_evt      = filt[3] ^ filt_q[3];
        adapter_chg = filt[0] ^ filt_q[0];
        button_chg  = filt[1] ^ filt_q[1];
    end

    // ----------------------------------------------------------------
    // register read decode
    // ----------------------------------------------------------------
    logic [pmief_pkg::FLAG_W-1:0] flags;
    logic [pmief_pkg::FLAG_W-1:0] mask;

    function automatic logic [7:0] read_reg(input logic [7:0] addr);
        logic [7:0] v;
        v = 8'h00;
        if (addr == pmief_pkg::REG_PART_ID) begin
            v = {PART_CODE, SILICON_STEP};
        end else if (addr == pmief_pkg::REG_EVENT) begin
            v = {2'b00, flags};
        end else if (addr == pmief_pkg::REG_MASK) begin
            v = {2'b00, mask};
        end else if (addr == pmief_pkg::REG_STATUS) begin
            v = {6'h00, filt[1], filt[0]};
        end
        return v;
    endfunction

    // ----------------------------------------------------------------
    // event flags, mask and interrupt
    // ----------------------------------------------------------------
    logic [2:0]                   prime;
    logic [2:0]                   next_prime;
    logic [pmief_pkg::FLAG_W-1:0] set;
    logic [pmief_pkg::FLAG_W-1:0] next_flags;
    logic [pmief_pkg::FLAG_W-1:0] next_mask;
    logic [7:0]                   next_rd_data;
    logic                         next_irq_out_n;
    logic                         clr;
    logic                         primed;

    always_comb begin
        // pin levels settle after reset; ignore pin changes until prime reaches PRIME_CYC
        primed     = (prime == pmief_pkg::PRIME_CYC);
        next_prime = primed ? prime : prime + 3'h1;
        set        = '0;
        set[pmief_pkg::BIT_LOW_SUPPLY] = events.low_supply_for_nvm_write;
        set[pmief_pkg::BIT_ADAPTER]    = adapter_chg & primed;
        set[pmief_pkg::BIT_BUTTON]     = button_chg & primed;
        set[pmief_pkg::BIT_CELL_DONE]  = events.backup_cell_measure_done;
        set[pmief_pkg::BIT_NVM_DONE]   = events.nvm_write_done;
        clr        = rd_evt && (ptr == pmief_pkg::REG_EVENT);
        next_flags = set | (clr ? '0 : flags);
        next_flags[pmief_pkg::BIT_THERMAL] = events.thermal_warning;
        next_mask = mask;
        if (wr_evt && (wr.addr == pmief_pkg::REG_MASK)) begin
            next_mask = wr.data[pmief_pkg::FLAG_W-1:0];
        end
        next_rd_data = rd_evt ? read_reg(ptr) : rd_data;
        next_irq_out_n = ~|(flags & ~mask);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            filt_q    <= 4'h0;
            prime     <= 3'h0;
            flags     <= pmief_pkg::EVENT_RST;
            mask      <= pmief_pkg::MASK_RST;
            rd_data   <= 8'h00;
            irq_out_n <= 1'b1;
        end else begin
            filt_q    <= next_filt_q;
            prime     <= next_prime;
            flags     <= next_flags;
            mask      <= next_mask;
            rd_data   <= next_rd_data;
            irq_out_n <= next_irq_out_n;
        end
    end

endmodule

`default_nettype wire

// ==== verilog/pmief_pkg.sv ====
// Purpose : shared constants and types for the identification and event-flag block
// Assumes : byte-wide registers reached over the two-wire serial link
// Notes   : register offsets are byte sub-addresses on the link

package pmief_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_PART_ID = 8'h00;
    localparam logic [7:0] REG_EVENT   = 8'h01;
    localparam logic [7:0] REG_MASK    = 8'h03;
    localparam logic [7:0] REG_STATUS  = 8'h05;

    // ----------------------------------------------------------------
    // field layout
    // ----------------------------------------------------------------
    localparam int PART_W  = 5;
    localparam int STEP_W  = 3;
    localparam int FLAG_W  = 6;
    localparam int STAT_W  = 2;

    localparam int BIT_LOW_SUPPLY = 5;
    localparam int BIT_ADAPTER    = 4;
    localparam int BIT_BUTTON     = 3;
    localparam int BIT_THERMAL    = 2;
    localparam int BIT_CELL_DONE  = 1;
    localparam int BIT_NVM_DONE   = 0;

    localparam int STAT_ADAPTER = 0;
    localparam int STAT_BUTTON  = 1;

    localparam logic [FLAG_W-1:0] EVENT_RST = 6'h00;
    localparam logic [FLAG_W-1:0] MASK_RST  = 6'h00;

    // ----------------------------------------------------------------
    // link framing
    // ----------------------------------------------------------------
    localparam logic [3:0] BIT_FIRST = 4'h1;
    localparam logic [3:0] BIT_LAST  = 4'h7;
    localparam logic [3:0] BIT_ZERO  = 4'h0;
    // outlasts the synchroniser latency plus one slipped sample
    localparam logic [2:0] PRIME_CYC = 3'h6;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AACK = 3'b010,
        ST_RX   = 3'b011,
        ST_WACK = 3'b100,
        ST_TX   = 3'b101,
        ST_MACK = 3'b110
    } pmief_state_t;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic low_supply_for_nvm_write;
        logic thermal_warning;
        logic backup_cell_measure_done;
        logic nvm_write_done;
    } pmief_events_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } pmief_wr_t;

endpackage

// ==== verilog/pmief_sync3.sv ====
// Purpose : three-stage synchroniser with a two-stage agreement filter
// Assumes : inputs are asynchronous to clk
// Notes   : output only follows once the second and third stages agree

`timescale 1ns/1ns
`default_nettype none

module pmief_sync3 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    generate
        if (W < 1) begin : g_bad_width
            $error("pmief_sync3 width must be at least one");
        end
    endgenerate

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_q;

    // s1 feeds s2 only; the filter looks at s2 and s3
    always_comb begin
        next_q = (s3 & ~(s2 ^ s3)) | (q & (s2 ^ s3));
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q  <= '0;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q  <= next_q;
        end
    end

endmodule

`default_nettype wire

// ==== tb/pmief_checker.sv ====
// Purpose : port-level checks for the identification and event-flag block
// Assumes : a frame opens with sda falling while scl is high
// Notes   : the mask is not visible here, so irq checks are causal only
`timescale 1ns/1ns
`default_nettype none
module pmief_checker #(
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    // system side
    input wire logic                     sys_clk,
    input wire logic                     rstn,
    input wire pmief_pkg::pmief_events_t events,
    input wire logic                     adapter_detect_pin,
    input wire logic                     button_pin,
    input wire logic                     irq_out_n,
    // serial link
    input wire logic                     scl_clk,
    input wire logic                     sda_i,
    input wire logic                     sda_o,
    input wire logic                     sda_oe_n
);
    // --------------------------------------------------------------
    // helper state
    // --------------------------------------------------------------
    logic [6:0] prev_in;
    logic [3:0] quiet;
    logic [3:0] next_quiet;
    logic       start_tog;
    logic       next_start_tog;
    logic       start_seen;
    logic [4:0] bit_cnt;
    logic [4:0] next_bit_cnt;
    logic [7:0] shift;
    logic       rd_frame;
    logic       next_rd_frame;
    logic       hit;
    logic       next_hit;

    // cycles since any event, pin or scl input moved; irq has no cause once this saturates
    always_comb begin
        next_quiet = quiet;
        if ({events, adapter_detect_pin, button_pin, scl_clk} != prev_in) begin
            next_quiet = 4'h0;
        end else if (quiet != 4'hf) begin
            next_quiet = quiet + 4'h1;
        end
        next_start_tog = scl_clk ? !start_tog : start_tog;
        next_bit_cnt   = (start_tog != start_seen) ? 5'h01 :
                         bit_cnt + {4'h0, bit_cnt != 5'h1f};
        next_rd_frame  = (bit_cnt == 5'h08) ? shift[0] : rd_frame;
        next_hit       = (bit_cnt == 5'h08) ? (shift[7:1] == DEV_ADDR) : hit;
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prev_in <= 7'h00;
            quiet   <= 4'h0;
        end else begin
            prev_in <= {events, adapter_detect_pin, button_pin, scl_clk};
            quiet   <= next_quiet;
        end
    end
    always_ff @(negedge sda_i or negedge rstn) begin
        if (!rstn) begin
            start_tog <= 1'b0;
        end else begin
            start_tog <= next_start_tog;
        end
    end
    always_ff @(posedge scl_clk or negedge rstn) begin
        if (!rstn) begin
            start_seen <= 1'b0;
            bit_cnt    <= 5'h1f;
            shift      <= 8'h00;
            rd_frame   <= 1'b0;
            hit        <= 1'b0;
        end else begin
            start_seen <= start_tog;
            bit_cnt    <= next_bit_cnt;
            shift      <= {shift[6:0], sda_i};
            rd_frame   <= next_rd_frame;
            hit        <= next_hit;
        end
    end

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    a_addr_ack: assert property (@(posedge scl_clk) disable iff (!rstn)
        bit_cnt == 5'h08 && shift[7:1] == DEV_ADDR |-> !sda_oe_n)
        else $error("own address not acknowledged");
    a_addr_nak: assert property (@(posedge scl_clk) disable iff (!rstn)
        bit_cnt == 5'h08 && shift[7:1] != DEV_ADDR |-> sda_oe_n)
        else $error("foreign address acknowledged");
    a_write_data_ack: assert property (@(posedge scl_clk) disable iff (!rstn)
        bit_cnt == 5'h11 && hit && !rd_frame |-> !sda_oe_n)
        else $error("written byte not acknowledged");
    a_mack_released: assert property (@(posedge scl_clk) disable iff (!rstn)
        bit_cnt == 5'h11 && hit && rd_frame |-> sda_oe_n)
        else $error("data line held in master ack slot");
    a_irq_needs_cause: assert property (@(posedge sys_clk) disable iff (!rstn)
        quiet == 4'hf |-> $stable(irq_out_n))
        else $error("irq moved with no cause");
    a_reset_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(rstn) |-> irq_out_n && sda_oe_n)
        else $error("outputs active right after reset");
    a_sda_value_low: assert property (@(posedge sys_clk) disable iff (!rstn)
        !sda_o)
        else $error("open drain value not low");
    a_idle_bus_free: assert property (@(posedge sys_clk) disable iff (!rstn)
        scl_clk [*8] |-> sda_oe_n)
        else $error("data line held while bus idle");

    c_irq_fall: cover property (@(posedge sys_clk) disable iff (!rstn) $fell(irq_out_n));
    c_addr_nak: cover property (@(posedge scl_clk) disable iff (!rstn)
        bit_cnt == 5'h08 && shift[7:1] != DEV_ADDR);
    c_read_done: cover property (@(posedge scl_clk) disable iff (!rstn)
        bit_cnt == 5'h11 && hit && rd_frame);
endmodule
`default_nettype wire

// ==== tb/pmief_host.sv ====
// Purpose : two-wire bus master standing in for the host processor
// Assumes : the data line has a pull-up; either party may only pull low
// Notes   : low phase is stretched before each ack slot of a sent byte and the first fetched bit, the device needs it
`timescale 1ns/1ns
`default_nettype none
module pmief_host #(
    parameter logic [6:0] DEV_ADDR = 7'h2a,
    parameter int         SLOW_LO  = 320
) (
    // link
    output logic      scl_clk,
    output logic      sda_i,
    input  wire logic sda_o,
    input  wire logic sda_oe_n
);
    logic drv_low = 1'b0;
    int   nak_cnt = 0;

    initial scl_clk = 1'b1;
    assign sda_i = drv_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_o);

    // scl is low on entry and on exit
    task automatic clk_bit(input logic b, input int lo, output logic got);
        #4 drv_low = !b;
        #(lo - 4) scl_clk = 1'b1;
        #8 got = sda_i;
        #8 scl_clk = 1'b0;
    endtask
    task automatic start();
        if (!scl_clk) begin
            #4 drv_low = 1'b0;
            #12 scl_clk = 1'b1;
        end
        #8 drv_low = 1'b1;
        #8 scl_clk = 1'b0;
    endtask
    task automatic stop();
        #4 drv_low = 1'b1;
        #12 scl_clk = 1'b1;
        #8 drv_low = 1'b0;
        #8;
    endtask
    task automatic send(input logic [7:0] b);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], 16, a);
        end
        clk_bit(1'b1, SLOW_LO, a);
        if (a) begin
            nak_cnt++;
        end
    endtask
    task automatic recv(output logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, (i == 7) ? SLOW_LO : 16, d[i]);
        end
        clk_bit(1'b1, 16, a);
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        start();
        send({DEV_ADDR, 1'b0});
        send(a);
        send(d);
        stop();
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        start();
        send({DEV_ADDR, 1'b0});
        send(a);
        start();
        send({DEV_ADDR, 1'b1});
        recv(d);
        stop();
    endtask
    task automatic probe(input logic [6:0] other);
        start();
        send({other, 1'b0});
        stop();
    endtask
endmodule
`default_nettype wire

// ==== tb/pmief_flags_tb_top.sv ====
// Purpose : self-checking bench for the identification and event-flag block
// Assumes : host model masters the link; other inputs move on falling sys_clk
// Notes   : random rounds mix latched events and pin changes, fixed seed
`timescale 1ns/1ns
`default_nettype none
module pmief_flags_tb_top;
    localparam logic [6:0] DEV  = 7'h31; // arbitrary value
    localparam logic [4:0] PART = 5'h0b; // arbitrary value
    localparam logic [2:0] STEP = 3'h6;  // arbitrary value

    logic                     sys_clk = 1'b0;
    logic                     rstn = 1'b0;
    logic                     scl_clk;
    logic                     sda_i;
    logic                     sda_o;
    logic                     sda_oe_n;
    logic                     adapter_detect_pin = 1'b0;
    logic                     button_pin = 1'b0;
    pmief_pkg::pmief_events_t events = '0;
    pmief_pkg::pmief_events_t ev;
    logic                     irq_out_n;
    int                       n_mismatch = 0;
    int                       compares = 0;
    logic [7:0]               rd;
    logic [7:0]               exp;
    logic [31:0]              r;

    always #25 sys_clk = ~sys_clk;

    pmief_flags #(.DEV_ADDR(DEV), .PART_CODE(PART), .SILICON_STEP(STEP)) pmief_flags_inst (
        .sys_clk, .rstn, .scl_clk, .sda_i, .sda_o, .sda_oe_n,
        .adapter_detect_pin, .button_pin, .events, .irq_out_n);
    pmief_host #(.DEV_ADDR(DEV)) pmief_host_inst (.scl_clk, .sda_i, .sda_o, .sda_oe_n);

    function automatic logic [7:0] flag_of(input pmief_pkg::pmief_events_t e,
                                           input logic ac, input logic bc);
        return {2'b00, e.low_supply_for_nvm_write, ac, bc, e.thermal_warning,
                e.backup_cell_measure_done, e.nvm_write_done};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        compares++;
        if (got !== want) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] want);
        pmief_host_inst.read_reg(a, rd);
        chk(rd, want);
    endtask
    task automatic chk_irq(input logic want_n);
        chk({7'h00, irq_out_n}, {7'h00, want_n});
    endtask
    task automatic pulse(input pmief_pkg::pmief_events_t e);
        @(negedge sys_clk) events = e;
        @(negedge sys_clk) events = '0;
    endtask
    // covers pin synchroniser, flag latch and irq register
    task automatic settle();
        repeat (16) @(negedge sys_clk);
    endtask
    task automatic summarize();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        r = $urandom(32'ha558);
        repeat (12) @(negedge sys_clk);
        rstn = 1'b1;
        settle();
        chk_rd(pmief_pkg::REG_PART_ID, {PART, STEP});
        pmief_host_inst.write_reg(pmief_pkg::REG_PART_ID, 8'hff);
        pmief_host_inst.write_reg(pmief_pkg::REG_EVENT, 8'hff);
        chk_rd(pmief_pkg::REG_PART_ID, {PART, STEP});
        chk_rd(pmief_pkg::REG_EVENT, 8'h00);
        chk_rd(8'h07, 8'h00);
        chk_irq(1'b1);
        pmief_host_inst.probe(~DEV);
        for (int n = 0; n < 24; n++) begin
            r = (n == 0) ? 32'h0 : (n == 1) ? 32'h1f : $urandom;
            ev = {r[0], 1'b0, r[1], r[2]};
            exp = flag_of(ev, r[3], r[4]);
            @(negedge sys_clk);
            adapter_detect_pin = adapter_detect_pin ^ r[3];
            button_pin = button_pin ^ r[4];
            pulse(ev);
            settle();
            chk_irq(exp == 8'h00);
            chk_rd(pmief_pkg::REG_EVENT, exp);
            chk_rd(pmief_pkg::REG_EVENT, 8'h00);
            chk_rd(pmief_pkg::REG_STATUS, {6'h00, button_pin, adapter_detect_pin});
            chk_irq(1'b1);
        end
        pmief_host_inst.write_reg(pmief_pkg::REG_MASK, 8'hff);
        chk_rd(pmief_pkg::REG_MASK, 8'h3f);
        pulse(4'h1);
        settle();
        chk_irq(1'b1);
        pmief_host_inst.write_reg(pmief_pkg::REG_MASK, 8'h00);
        settle();
        chk_irq(1'b0);
        chk_rd(pmief_pkg::REG_EVENT, 8'h01);
        @(negedge sys_clk) events = 4'hc;
        settle();
        chk_irq(1'b0);
        chk_rd(pmief_pkg::REG_EVENT, 8'h24);
        chk_rd(pmief_pkg::REG_EVENT, 8'h24);
        @(negedge sys_clk) events = 4'h0;
        chk_rd(pmief_pkg::REG_EVENT, 8'h20);
        settle();
        chk_irq(1'b1);
        chk_rd(pmief_pkg::REG_EVENT, 8'h00);
        pulse(4'h2);
        @(negedge sys_clk) rstn = 1'b0;
        @(negedge sys_clk) rstn = 1'b1;
        settle();
        chk_irq(1'b1);
        chk_rd(pmief_pkg::REG_EVENT, 8'h00);
        chk({7'h00, pmief_host_inst.nak_cnt == 1}, 8'h01);
        summarize();
    end

    // the sequence needs well under half a millisecond
    initial begin
        #2_000_000;
        n_mismatch++;
        summarize();
    end
endmodule

bind pmief_flags pmief_checker #(.DEV_ADDR(DEV_ADDR)) pmief_checker_inst (
    .sys_clk, .rstn, .events, .adapter_detect_pin, .button_pin, .irq_out_n,
    .scl_clk, .sda_i, .sda_o, .sda_oe_n);
`default_nettype wire
